/* logic/pll_serial_defines.vh */
// Summary of operation
// [RQ1] Select 00 loads IF reference latch, 14-bit
// [RQ2] IF ref: divide 15:2, flags 17 to 21
// [RQ3] IF polarity 1 positive, 0 negative VCO
// [RQ4] IF pump three-state 1, normal 0
// [RQ5] IF gain: 0 low, 1 high current
// [RQ6] Select 01 loads IF A/B divider
// [RQ7] IF divider bit picks 8/9 or 16/17
// [RQ8] Select 10 loads RF reference latch, 14-bit
// [RQ9] RF polarity 1 positive, 0 negative VCO
// [RQ10] RF pump three-state 1, normal 0
// [RQ11] RF gain: 0 low, 1 high current
// [RQ12] Select 11 loads RF A/B divider
// [RQ13] RF divider bit picks 32/33 or 64/65
// [RQ14] RF divider gain bit enables fastlock
// [RQ15] Fastlock forces maximum RF pump current
// [RQ16] Fastlock drives damping resistor switch output
// [RQ17] Host clears gain bit to leave fastlock
// [RQ18] Shift on serial rise, latch on strobe rise
// [RQ19] Host serial clock at most 20 MHz
// [RQ20] Byte host sends three bytes, then strobe
// [RQ21] All four latches written before outputs active
// [RQ22] MSB first, two LSBs select latch
// [RQ23] IF bit 20: 0 is 8/9, 1 is 16/17
// [RQ24] RF bit 20: 0 is 64/65, 1 is 32/33
// [RQ25] Unaddressed latches hold; last 22 bits kept
`ifndef PLL_SERIAL_DEFINES_VH
`define PLL_SERIAL_DEFINES_VH

`define WORD_W        22
`define SEL_IF_REF    2'h0
`define SEL_IF_DIV    2'h1
`define SEL_RF_REF    2'h2
`define SEL_RF_DIV    2'h3
`define SEL_LSB       0
`define SEL_MSB       1
`define REF_LSB       2
`define REF_MSB       15
`define POL_BIT       17
`define GAIN_BIT      18
`define HIZ_BIT       19
`define LOCKDET_BIT   20
`define OUTSEL_BIT    21
`define SWAL_LSB      2
`define SWAL_MSB      7
`define MAIN_LSB      8
`define MAIN_MSB      18
`define FASTLOCK_BIT  19
`define MODULUS_BIT   20
`define PDOWN_BIT     21
`define LATCH_RESET   22'h000000
`define ALL_WRITTEN   4'hf

`endif

/* logic/pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage is read only by the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pin_sync

`default_nettype wire

/* logic/pll_serial_latches.v */
`timescale 1ns/1ps
`default_nettype none
`include "pll_serial_defines.vh"

module pll_serial_latches #(
  parameter WORD_W = `WORD_W
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        serial_clk,
  input  wire        serial_data_in,
  input  wire        latch_strobe,
  output wire [13:0] if_ref_div,
  output wire        if_pd_sense,
  output wire        if_pump_gain,
  output wire        if_pump_hiz,
  output wire        if_lockdet_select,
  output wire        if_output_select,
  output wire [5:0]  if_swallow_count,
  output wire [10:0] if_main_count,
  output wire        if_modulus_select,
  output wire        if_powerdown,
  output wire [13:0] rf_ref_div,
  output wire        rf_pd_sense,
  output wire        rf_pump_gain,
  output wire        rf_pump_hiz,
  output wire [5:0]  rf_swallow_count,
  output wire [10:0] rf_main_count,
  output wire        rf_modulus_select,
  output wire        rf_powerdown,
  output wire        rf_fastlock_enable,
  output wire        rf_pump_max,
  output wire        fastlock_switch_out,
  output wire        outputs_active
);

  // ****************************************
  // Power-up states
  // ****************************************
  localparam [1:0] ST_UNCONFIG = 2'h1;
  localparam [1:0] ST_ACTIVE   = 2'h2;

  // ****************************************
  // Declarations
  // ****************************************
  wire [2:0]        pins_sync;
  wire              sclk_lvl;
  wire              serial_data_in_lvl;
  wire              strobe_lvl;
  wire              sclk_rise;
  wire              strobe_rise;
  wire [1:0]        sel_code;
  reg               sclk_prev_ff;
  reg               strobe_prev_ff;
  reg  [WORD_W-1:0] shift_ff;
  reg  [WORD_W-1:0] if_ref_ff;
  reg  [WORD_W-1:0] if_div_ff;
  reg  [WORD_W-1:0] rf_ref_ff;
  reg  [WORD_W-1:0] rf_div_ff;
  reg  [3:0]        written_ff;
  reg  [3:0]        nxt_written;
  reg  [1:0]        state_ff;
  reg  [1:0]        nxt_state;
  reg  [13:0]       if_ref_div_ff;
  reg               if_pd_sense_ff;
  reg               if_pump_gain_ff;
  reg               if_pump_hiz_ff;
  reg               if_lockdet_ff;
  reg               if_outsel_ff;
  reg  [5:0]        if_swallow_ff;
  reg  [10:0]       if_main_ff;
  reg               if_modulus_ff;
  reg               if_powerdown_ff;
  reg  [13:0]       rf_ref_div_ff;
  reg               rf_pd_sense_ff;
  reg               rf_pump_gain_ff;
  reg               rf_pump_hiz_ff;
  reg  [5:0]        rf_swallow_ff;
  reg  [10:0]       rf_main_ff;
  reg               rf_modulus_ff;
  reg               rf_powerdown_ff;
  reg               rf_fastlock_ff;
  reg               rf_pump_max_ff;
  reg               fastlock_sw_ff;
  reg               active_ff;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  // Serial pins are asynchronous to clk; host clock is far slower
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({latch_strobe, serial_data_in, serial_clk}),
    .sync_out (pins_sync)
  );

  assign sclk_lvl   = pins_sync[0];
  assign serial_data_in_lvl  = pins_sync[1];
  assign strobe_lvl = pins_sync[2];

  // ****************************************
  // Edge detection
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      sclk_prev_ff   <= 1'b0;
      strobe_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff   <= sclk_lvl;
      strobe_prev_ff <= strobe_lvl;
    end
  end

  // Data was sampled alongside the clock, so it lines up with the edge
  assign sclk_rise   = sclk_lvl & ~sclk_prev_ff;
  assign strobe_rise = strobe_lvl & ~strobe_prev_ff;

  // ****************************************
  // Input shift register
  // ****************************************
  // Oldest bits fall off the top, so only the last word is kept
  always @(posedge clk) begin
    if (rst) begin
      shift_ff <= `LATCH_RESET;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[WORD_W-2:0], serial_data_in_lvl}; // RQ18 RQ22 RQ25
    end
  end

  // Last two bits shifted in are the select code
  assign sel_code = shift_ff[`SEL_MSB:`SEL_LSB]; // RQ22

  // ****************************************
  // Latch transfer
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      if_ref_ff <= `LATCH_RESET;
      if_div_ff <= `LATCH_RESET;
      rf_ref_ff <= `LATCH_RESET;
      rf_div_ff <= `LATCH_RESET;
    end else if (strobe_rise) begin // RQ18
      // Latches not selected keep their contents
      case (sel_code)
        `SEL_IF_REF: begin
          if_ref_ff <= shift_ff; // RQ1
        end
        `SEL_IF_DIV: begin
          if_div_ff <= shift_ff; // RQ6
        end
        `SEL_RF_REF: begin
          rf_ref_ff <= shift_ff; // RQ8
        end
        `SEL_RF_DIV: begin
          rf_div_ff <= shift_ff; // RQ12 RQ25
        end
        default: begin
          if_ref_ff <= if_ref_ff;
        end
      endcase
    end
  end

  // ****************************************
  // Power-up tracking
  // ****************************************
  always @* begin
    nxt_written = written_ff;
    if (strobe_rise) begin
      case (sel_code)
        `SEL_IF_REF: nxt_written = written_ff | 4'h1;
        `SEL_IF_DIV: nxt_written = written_ff | 4'h2;
        `SEL_RF_REF: nxt_written = written_ff | 4'h4;
        `SEL_RF_DIV: nxt_written = written_ff | 4'h8;
        default:     nxt_written = written_ff;
      endcase
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_UNCONFIG: begin
        if (written_ff == `ALL_WRITTEN) begin
          nxt_state = ST_ACTIVE; // RQ21
        end
      end
      ST_ACTIVE: begin
        nxt_state = ST_ACTIVE;
      end
      default: begin
        nxt_state = ST_UNCONFIG;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      written_ff <= 4'h0;
      state_ff   <= ST_UNCONFIG;
    end else begin
      written_ff <= nxt_written;
      state_ff   <= nxt_state;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  // Pump release and fastlock wait until all four latches are loaded
  wire              configured;
  wire [13:0]       nxt_if_ref_div;
  wire              nxt_if_pd_sense;
  wire              nxt_if_pump_gain;
  wire              nxt_if_pump_hiz;
  wire              nxt_if_lockdet;
  wire              nxt_if_outsel;
  wire [5:0]        nxt_if_swallow;
  wire [10:0]       nxt_if_main;
  wire              nxt_if_modulus;
  wire              nxt_if_powerdown;
  wire [13:0]       nxt_rf_ref_div;
  wire              nxt_rf_pd_sense;
  wire              nxt_rf_pump_gain;
  wire              nxt_rf_pump_hiz;
  wire [5:0]        nxt_rf_swallow;
  wire [10:0]       nxt_rf_main;
  wire              nxt_rf_modulus;
  wire              nxt_rf_powerdown;
  wire              nxt_rf_fastlock;
  wire              nxt_rf_pump_max;
  wire              nxt_fastlock_sw;
  wire              nxt_active;

  assign configured       = state_ff[1]; // RQ21
  assign nxt_if_ref_div   = if_ref_ff[`REF_MSB:`REF_LSB]; // RQ1 RQ2
  assign nxt_if_pd_sense  = if_ref_ff[`POL_BIT]; // RQ3
  assign nxt_if_pump_gain = if_ref_ff[`GAIN_BIT]; // RQ5
  assign nxt_if_pump_hiz  = if_ref_ff[`HIZ_BIT] | ~configured; // RQ4 RQ21
  assign nxt_if_lockdet   = if_ref_ff[`LOCKDET_BIT]; // RQ2
  assign nxt_if_outsel    = if_ref_ff[`OUTSEL_BIT]; // RQ2
  assign nxt_if_swallow   = if_div_ff[`SWAL_MSB:`SWAL_LSB]; // RQ6
  assign nxt_if_main      = if_div_ff[`MAIN_MSB:`MAIN_LSB]; // RQ6
  assign nxt_if_modulus   = if_div_ff[`MODULUS_BIT]; // RQ7 RQ23
  assign nxt_if_powerdown = if_div_ff[`PDOWN_BIT];
  assign nxt_rf_ref_div   = rf_ref_ff[`REF_MSB:`REF_LSB]; // RQ8
  assign nxt_rf_pd_sense  = rf_ref_ff[`POL_BIT]; // RQ9
  assign nxt_rf_pump_gain = rf_ref_ff[`GAIN_BIT]; // RQ11
  assign nxt_rf_pump_hiz  = rf_ref_ff[`HIZ_BIT] | ~configured; // RQ10 RQ21
  assign nxt_rf_swallow   = rf_div_ff[`SWAL_MSB:`SWAL_LSB]; // RQ12
  assign nxt_rf_main      = rf_div_ff[`MAIN_MSB:`MAIN_LSB]; // RQ12
  assign nxt_rf_modulus   = rf_div_ff[`MODULUS_BIT]; // RQ13 RQ24
  assign nxt_rf_powerdown = rf_div_ff[`PDOWN_BIT];
  assign nxt_rf_fastlock  = rf_div_ff[`FASTLOCK_BIT] & configured; // RQ14 RQ17
  assign nxt_rf_pump_max  = nxt_rf_pump_gain | nxt_rf_fastlock; // RQ15
  assign nxt_fastlock_sw  = nxt_rf_fastlock; // RQ16
  assign nxt_active       = configured; // RQ21

  // ****************************************
  // IF output registers
  // ****************************************
  // Until configured the pump stays three-stated and fastlock off
  always @(posedge clk) begin
    if (rst) begin
      if_ref_div_ff   <= 14'h0000;
      if_pd_sense_ff  <= 1'b0;
      if_pump_gain_ff <= 1'b0;
      if_pump_hiz_ff  <= 1'b1;
      if_lockdet_ff   <= 1'b0;
      if_outsel_ff    <= 1'b0;
      if_swallow_ff   <= 6'h00;
      if_main_ff      <= 11'h000;
      if_modulus_ff   <= 1'b0;
      if_powerdown_ff <= 1'b0;
    end else begin
      if_ref_div_ff   <= nxt_if_ref_div; // RQ1 RQ2
      if_pd_sense_ff  <= nxt_if_pd_sense; // RQ3
      if_pump_gain_ff <= nxt_if_pump_gain; // RQ5
      if_pump_hiz_ff  <= nxt_if_pump_hiz; // RQ4 RQ21
      if_lockdet_ff   <= nxt_if_lockdet; // RQ2
      if_outsel_ff    <= nxt_if_outsel; // RQ2
      if_swallow_ff   <= nxt_if_swallow; // RQ6
      if_main_ff      <= nxt_if_main; // RQ6
      if_modulus_ff   <= nxt_if_modulus; // RQ7 RQ23
      if_powerdown_ff <= nxt_if_powerdown;
    end
  end

  // ****************************************
  // RF output registers
  // ****************************************
  // Fastlock lasts until the host rewrites the divider with it clear
  always @(posedge clk) begin
    if (rst) begin
      rf_ref_div_ff   <= 14'h0000;
      rf_pd_sense_ff  <= 1'b0;
      rf_pump_gain_ff <= 1'b0;
      rf_pump_hiz_ff  <= 1'b1;
      rf_swallow_ff   <= 6'h00;
      rf_main_ff      <= 11'h000;
      rf_modulus_ff   <= 1'b0;
      rf_powerdown_ff <= 1'b0;
      rf_fastlock_ff  <= 1'b0;
      rf_pump_max_ff  <= 1'b0;
      fastlock_sw_ff  <= 1'b0;
    end else begin
      rf_ref_div_ff   <= nxt_rf_ref_div; // RQ8
      rf_pd_sense_ff  <= nxt_rf_pd_sense; // RQ9
      rf_pump_gain_ff <= nxt_rf_pump_gain; // RQ11
      rf_pump_hiz_ff  <= nxt_rf_pump_hiz; // RQ10 RQ21
      rf_swallow_ff   <= nxt_rf_swallow; // RQ12
      rf_main_ff      <= nxt_rf_main; // RQ12
      rf_modulus_ff   <= nxt_rf_modulus; // RQ13 RQ24
      rf_powerdown_ff <= nxt_rf_powerdown;
      rf_fastlock_ff  <= nxt_rf_fastlock; // RQ14 RQ17
      rf_pump_max_ff  <= nxt_rf_pump_max; // RQ15
      fastlock_sw_ff  <= nxt_fastlock_sw; // RQ16
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active; // RQ21
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign if_ref_div          = if_ref_div_ff;
  assign if_pd_sense         = if_pd_sense_ff;
  assign if_pump_gain        = if_pump_gain_ff;
  assign if_pump_hiz         = if_pump_hiz_ff;
  assign if_lockdet_select   = if_lockdet_ff;
  assign if_output_select    = if_outsel_ff;
  assign if_swallow_count    = if_swallow_ff;
  assign if_main_count       = if_main_ff;
  assign if_modulus_select   = if_modulus_ff;
  assign if_powerdown        = if_powerdown_ff;
  assign rf_ref_div          = rf_ref_div_ff;
  assign rf_pd_sense         = rf_pd_sense_ff;
  assign rf_pump_gain        = rf_pump_gain_ff;
  assign rf_pump_hiz         = rf_pump_hiz_ff;
  assign rf_swallow_count    = rf_swallow_ff;
  assign rf_main_count       = rf_main_ff;
  assign rf_modulus_select   = rf_modulus_ff;
  assign rf_powerdown        = rf_powerdown_ff;
  assign rf_fastlock_enable  = rf_fastlock_ff;
  assign rf_pump_max         = rf_pump_max_ff;
  assign fastlock_switch_out = fastlock_sw_ff;
  assign outputs_active      = active_ff;

endmodule // pll_serial_latches

`default_nettype wire

/* verif/pll_serial_latches_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pll_serial_latches_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        latch_strobe,
  input wire logic [13:0] if_ref_div,
  input wire logic [10:0] rf_main_count,
  input wire logic        if_pump_hiz,
  input wire logic        rf_pump_hiz,
  input wire logic        rf_pump_gain,
  input wire logic        rf_pump_max,
  input wire logic        rf_fastlock_enable,
  input wire logic        fastlock_switch_out,
  input wire logic        outputs_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Checks
  // ****
  // Eight quiet cycles outlast the pin-to-output lag
  sequence strobe_quiet;
    !latch_strobe [*8];
  endsequence
  a_latch_held: assert property (strobe_quiet |=> $stable({if_ref_div, rf_main_count}))
    else $error("latch changed without strobe");
  a_fastlock_switch: assert property (fastlock_switch_out == rf_fastlock_enable)
    else $error("switch output differs from fastlock");
  a_fastlock_max: assert property (fastlock_switch_out |-> rf_pump_max)
    else $error("fastlock without max current");
  a_gain_max: assert property (rf_pump_gain |-> rf_pump_max)
    else $error("gain bit without max current");
  a_max_cause: assert property (rf_pump_max |-> rf_pump_gain || rf_fastlock_enable)
    else $error("max current without cause");
  a_if_pump_config: assert property ($fell(if_pump_hiz) |-> ##[0:3] outputs_active)
    else $error("IF pump released before setup");
  a_rf_pump_config: assert property ($fell(rf_pump_hiz) |-> ##[0:3] outputs_active)
    else $error("RF pump released before setup");
  a_fastlock_config: assert property ($rose(fastlock_switch_out) |-> ##[0:3] outputs_active)
    else $error("fastlock before setup");
  a_active_sticky: assert property (outputs_active |=> outputs_active)
    else $error("outputs went inactive");
endmodule // pll_serial_latches_sva
`default_nettype wire

/* verif/serial_host.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input  wire logic clk,
  output var  logic serial_clk,
  output var  logic serial_data_in,
  output var  logic latch_strobe
);
  // ****
  // Host side of the three-wire link
  // ****
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
  end
  // Clock stands low between frames; 80 ns period stays under the host limit
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    // Released data line must not look like a held bit
    serial_data_in = ~serial_data_in;
    repeat (4) @(negedge clk);
    latch_strobe = 1'b1;
    repeat (4) @(negedge clk);
    latch_strobe = 1'b0;
  endtask
endmodule // serial_host
`default_nettype wire

/* verif/test_dual_pll_serial_latches.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dual_pll_serial_latches;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  int          errors = 0;
  int          n_compared = 0;
  wire         sclk, sdat, stb;
  wire  [13:0] if_ref_div, rf_ref_div;
  wire  [10:0] if_main_count, rf_main_count;
  wire  [5:0]  if_swallow_count, rf_swallow_count;
  wire         if_pd_sense, if_pump_gain, if_pump_hiz, if_lockdet_select, if_output_select;
  wire         if_modulus_select, if_powerdown, rf_pd_sense, rf_pump_gain, rf_pump_hiz;
  wire         rf_modulus_select, rf_powerdown, rf_fastlock_enable, rf_pump_max;
  wire         fastlock_switch_out, outputs_active;
  // ****
  // Design and host
  // ****
  pll_serial_latches dut_u (.clk(clk), .rst(rst), .serial_clk(sclk), .serial_data_in(sdat),
    .latch_strobe(stb), .if_ref_div(if_ref_div), .if_pd_sense(if_pd_sense),
    .if_pump_gain(if_pump_gain), .if_pump_hiz(if_pump_hiz),
    .if_lockdet_select(if_lockdet_select), .if_output_select(if_output_select),
    .if_swallow_count(if_swallow_count), .if_main_count(if_main_count),
    .if_modulus_select(if_modulus_select), .if_powerdown(if_powerdown),
    .rf_ref_div(rf_ref_div), .rf_pd_sense(rf_pd_sense), .rf_pump_gain(rf_pump_gain),
    .rf_pump_hiz(rf_pump_hiz), .rf_swallow_count(rf_swallow_count),
    .rf_main_count(rf_main_count), .rf_modulus_select(rf_modulus_select),
    .rf_powerdown(rf_powerdown), .rf_fastlock_enable(rf_fastlock_enable),
    .rf_pump_max(rf_pump_max), .fastlock_switch_out(fastlock_switch_out),
    .outputs_active(outputs_active));
  serial_host host_u (.clk(clk), .serial_clk(sclk), .serial_data_in(sdat), .latch_strobe(stb));
  always #5 clk = ~clk;
  // ****
  // Helpers
  // ****
  task automatic chk(input string nm, input logic [21:0] got, input logic [21:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Fixed wait covers the pin-to-output and active-flag lag
  task automatic wr(input logic [23:0] w, input int n);
    host_u.send(w, n);
    repeat (12) @(negedge clk);
  endtask
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    chk("idle outputs", {if_pump_hiz, rf_pump_hiz, fastlock_switch_out, outputs_active}, 4'hc);
    $display("t_reset done");
  endtask
  task automatic t_config;
    // Junk leading bits exercise the byte-host path
    wr({2'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 14'h1234, 2'h0}, 24);
    wr({2'h0, 1'b0, 1'b1, 1'b0, 11'h5a5, 6'h2b, 2'h1}, 22);
    wr({2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 14'h0041, 2'h2}, 22);
    chk("pump before setup", {outputs_active, if_pump_hiz}, 2'h1);
    wr({2'h0, 1'b0, 1'b0, 1'b1, 11'h3ff, 6'h3f, 2'h3}, 22);
    chk("active", outputs_active, 1'b1);
    chk("if ref", {if_output_select, if_lockdet_select, if_pump_hiz, if_pump_gain, if_pd_sense,
      if_ref_div}, {1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 14'h1234});
    chk("if div", {if_powerdown, if_modulus_select, if_main_count, if_swallow_count},
      {1'b0, 1'b1, 11'h5a5, 6'h2b});
    chk("rf ref", {rf_pump_hiz, rf_pump_gain, rf_pd_sense, rf_ref_div},
      {1'b1, 1'b0, 1'b0, 14'h0041});
    chk("rf div", {rf_powerdown, rf_modulus_select, rf_fastlock_enable, rf_main_count,
      rf_swallow_count}, {1'b0, 1'b0, 1'b1, 11'h3ff, 6'h3f});
    chk("fastlock on", {fastlock_switch_out, rf_pump_max}, 2'h3);
    $display("t_config done");
  endtask
  task automatic t_fastlock;
    wr({2'h0, 1'b1, 1'b1, 1'b0, 11'h001, 6'h01, 2'h3}, 22);
    chk("fastlock off", {fastlock_switch_out, rf_pump_max, rf_modulus_select, rf_powerdown,
      rf_main_count}, {1'b0, 1'b0, 1'b1, 1'b1, 11'h001});
    wr({2'h0, 1'b0, 1'b0, 1'b0, 11'h7ff, 6'h00, 2'h1}, 22);
    chk("if modulus", {if_modulus_select, if_main_count}, {1'b0, 11'h7ff});
    wr({2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 14'h3fff, 2'h2}, 22);
    chk("rf gain", {rf_pump_max, rf_pump_hiz, rf_pump_gain, rf_pd_sense, rf_ref_div},
      {1'b1, 1'b0, 1'b1, 1'b1, 14'h3fff});
    chk("if ref held", if_ref_div, 14'h1234);
    $display("t_fastlock done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_config();
    t_fastlock();
    results();
  end
endmodule // test_dual_pll_serial_latches
bind pll_serial_latches pll_serial_latches_sva chk_u (.clk(clk), .rst(rst),
  .latch_strobe(latch_strobe), .if_ref_div(if_ref_div), .rf_main_count(rf_main_count),
  .if_pump_hiz(if_pump_hiz), .rf_pump_hiz(rf_pump_hiz), .rf_pump_gain(rf_pump_gain),
  .rf_pump_max(rf_pump_max), .rf_fastlock_enable(rf_fastlock_enable),
  .fastlock_switch_out(fastlock_switch_out), .outputs_active(outputs_active));
`default_nettype wire
